/* File: icm_top.sv */
// Purpose: Direct-mapped instruction store with mapped tag and data arrays
// Assumes: Fetch, memory and translation requests held until answered
// Notes:   APB slave for mapped arrays and control word
`timescale 1ns/1ns

module icm_top (
  // Clock and resets
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              manual_reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Fetch port
  input  wire logic              fetch_req,
  input  wire icm_pkg::icm_fetch_t fetch_in,
  output logic                   fetch_ack,
  output logic      [31:0]       fetch_instr,
  output logic                   fetch_hit,
  output logic                   fetch_err,
  // External memory read port
  output logic                   mem_req,
  output logic      [28:0]       mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  // Fetch translation buffer port
  input  wire logic              xlat_en,
  output logic                   xlat_req,
  output logic      [21:0]       xlat_va,
  input  wire logic              xlat_done,
  input  wire icm_pkg::icm_xlat_t xlat_rsp,
  output logic                   multi_hit_exc
);

  // ********************
  // Storage
  // ********************
  logic [icm_pkg::TAG_W-1:0] tag_mem  [icm_pkg::LINES];
  logic [31:0]               data_mem [icm_pkg::LINES*icm_pkg::WORDS];
  logic [icm_pkg::LINES-1:0] valid_r;

  // ********************
  // State
  // ********************
  icm_pkg::icm_state_t       state_r;
  logic [1:0]                ctrl_r;
  logic [icm_pkg::IDX_W-1:0] line_r;
  logic [28:0]               pa_r;
  logic                      ack_r;
  logic [31:0]               instr_r;
  logic                      hit_r;
  logic                      err_r;
  logic [31:0]               prdata_r;
  logic                      slverr_r;
  logic                      xlat_ok_r;
  logic                      xlat_multi_r;
  logic [icm_pkg::TAG_W-1:0] xlat_ppn_r;
  logic                      exc_r;
  logic                      last_hit_r;
  logic [icm_pkg::IDX_W-1:0] last_line_r;

  // ********************
  // Decode
  // ********************
  logic                      store_en;
  logic                      hi_ix;
  logic [7:0]                region;
  logic                      is_tag;
  logic                      is_data;
  logic                      is_ctrl;
  logic                      is_stat;
  logic                      is_assoc;
  logic [icm_pkg::IDX_W-1:0] map_line;
  logic [icm_pkg::WRD_W-1:0] map_word;
  logic                      apb_acc;
  logic                      fetch_map;
  logic                      lookup;
  logic [icm_pkg::IDX_W-1:0] f_line;
  logic [icm_pkg::WRD_W-1:0] f_word;
  logic                      f_hit;
  logic                      take_fetch;
  logic                      fill_start;
  logic [icm_pkg::WRD_W-1:0] fill_word;
  logic                      fill_first;
  logic                      fill_last;
  logic                      fill_step;
  logic [18:0]               cmp_tag;

  assign store_en  = ctrl_r[icm_pkg::CTRL_EN_BIT];
  assign hi_ix     = ctrl_r[icm_pkg::CTRL_IX_BIT];
  assign region    = paddr[icm_pkg::REGION_HI:icm_pkg::REGION_LO];
  assign is_tag    = (region == icm_pkg::TAG_REGION);
  assign is_data   = (region == icm_pkg::DATA_REGION);
  assign is_ctrl   = (paddr == icm_pkg::CTRL_ADDR);
  assign is_stat   = (paddr == icm_pkg::STAT_ADDR);
  assign is_assoc  = paddr[icm_pkg::ASSOC_BIT];
  assign map_line  = paddr[icm_pkg::IDX_HI:icm_pkg::IDX_LO];
  assign map_word  = paddr[icm_pkg::WRD_HI:icm_pkg::WRD_LO];
  assign apb_acc   = psel && penable;

  // Fetch index, tag compare and word pick
  assign f_line    = hi_ix ? {fetch_in.ea[icm_pkg::IDX_ALT],
                              fetch_in.ea[icm_pkg::IDX_HI-1:icm_pkg::IDX_LO]}
                           : fetch_in.ea[icm_pkg::IDX_HI:icm_pkg::IDX_LO];
  assign f_word    = fetch_in.ea[icm_pkg::WRD_HI:icm_pkg::WRD_LO];
  assign f_hit     = valid_r[f_line] &&
                     (tag_mem[f_line] == fetch_in.pa[icm_pkg::TAG_HI:icm_pkg::TAG_LO]);
  assign fetch_map = (fetch_in.ea[31:24] == icm_pkg::TAG_REGION) ||
                     (fetch_in.ea[31:24] == icm_pkg::DATA_REGION);
  assign lookup    = store_en && fetch_in.cacheable;
  assign take_fetch = (state_r == icm_pkg::ST_IDLE) && !apb_acc && fetch_req && !ack_r;
  assign fill_start = take_fetch && !fetch_map && lookup && !f_hit;
  assign fill_step  = (state_r == icm_pkg::ST_FILL) && mem_ack;

  // Associative compare tag, translated or taken as is
  assign cmp_tag   = xlat_en ? xlat_ppn_r : pwdata[icm_pkg::TAG_HI:icm_pkg::TAG_LO];

  // ********************
  // Wraparound sequencer
  // ********************
  icm_fill_seq #(
    .WORDS      (icm_pkg::WORDS)
  ) u_seq (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (fill_start),
    .start_word (f_word),
    .step       (fill_step),
    .word       (fill_word),
    .first      (fill_first),
    .last       (fill_last)
  );

  // ********************
  // Control word
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= icm_pkg::CTRL_RESET;
    else if (manual_reset)
      ctrl_r <= icm_pkg::CTRL_RESET;
    else if (state_r == icm_pkg::ST_APB && pwrite && is_ctrl)
      ctrl_r <= pwdata[1:0];
  end

  // ********************
  // Sequencing
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= icm_pkg::ST_IDLE;
    else if (manual_reset)
      state_r <= icm_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        icm_pkg::ST_IDLE:
        begin
          if (apb_acc && pwrite && is_tag && is_assoc && xlat_en)
            state_r <= icm_pkg::ST_XLAT;
          else if (apb_acc)
            state_r <= icm_pkg::ST_APB;
          else if (fill_start)
            state_r <= icm_pkg::ST_FILL;
          else if (take_fetch && !fetch_map && !lookup)
            state_r <= icm_pkg::ST_SINGLE;
        end
        icm_pkg::ST_FILL:
        begin
          if (mem_ack && fill_last)
            state_r <= icm_pkg::ST_IDLE;
        end
        icm_pkg::ST_SINGLE:
        begin
          if (mem_ack)
            state_r <= icm_pkg::ST_IDLE;
        end
        icm_pkg::ST_XLAT:
        begin
          if (xlat_done)
            state_r <= icm_pkg::ST_APB;
        end
        icm_pkg::ST_APB:
          state_r <= icm_pkg::ST_IDLE;
        default:
          state_r <= icm_pkg::ST_IDLE;
      endcase
    end
  end

  // Captured miss context
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_r <= '0;
      pa_r   <= '0;
    end
    else if (take_fetch)
    begin
      line_r <= f_line;
      pa_r   <= fetch_in.pa;
    end
  end

  // ********************
  // Fetch answer
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_r   <= 1'b0;
      instr_r <= '0;
      hit_r   <= 1'b0;
      err_r   <= 1'b0;
    end
    else if (manual_reset)
    begin
      ack_r <= 1'b0;
      hit_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      ack_r <= 1'b0;
      if (take_fetch && fetch_map)
      begin
        ack_r <= 1'b1;
        err_r <= 1'b1;
        hit_r <= 1'b0;
      end
      else if (take_fetch && lookup && f_hit)
      begin
        ack_r   <= 1'b1;
        instr_r <= data_mem[{f_line, f_word}];
        err_r   <= 1'b0;
        hit_r   <= 1'b1;
      end
      else if ((fill_step && fill_first) || (state_r == icm_pkg::ST_SINGLE && mem_ack))
      begin
        ack_r   <= 1'b1;
        instr_r <= mem_rdata;
        err_r   <= 1'b0;
        hit_r   <= 1'b0;
      end
    end
  end

  // Last lookup outcome for status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_hit_r  <= 1'b0;
      last_line_r <= '0;
    end
    else if (take_fetch && lookup && !fetch_map)
    begin
      last_hit_r  <= f_hit;
      last_line_r <= f_line;
    end
  end

  // ********************
  // Valid flags
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      valid_r <= '0;
    else if (fill_start)
      valid_r[f_line] <= 1'b0;
    else if (fill_step && fill_last)
      valid_r[line_r] <= 1'b1;
    else if (state_r == icm_pkg::ST_APB && pwrite && is_tag)
    begin
      if (!is_assoc)
        valid_r[map_line] <= pwdata[icm_pkg::VALID_BIT];
      else if (xlat_ok_r && !xlat_multi_r && valid_r[map_line] && tag_mem[map_line] == cmp_tag)
        valid_r[map_line] <= pwdata[icm_pkg::VALID_BIT];
    end
  end

  // ********************
  // Tag and data arrays, no reset
  // ********************
  always_ff @(posedge pclk)
  begin
    if (fill_step && fill_last)
      tag_mem[line_r] <= pa_r[icm_pkg::TAG_HI:icm_pkg::TAG_LO];
    else if (state_r == icm_pkg::ST_APB && pwrite && is_tag && !is_assoc)
      tag_mem[map_line] <= pwdata[icm_pkg::TAG_HI:icm_pkg::TAG_LO];
  end

  always_ff @(posedge pclk)
  begin
    if (fill_step)
      data_mem[{line_r, fill_word}] <= mem_rdata;
    else if (state_r == icm_pkg::ST_APB && pwrite && is_data)
      data_mem[{map_line, map_word}] <= pwdata;
  end

  // ********************
  // Translation result
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xlat_ok_r    <= 1'b0;
      xlat_multi_r <= 1'b0;
      xlat_ppn_r   <= '0;
    end
    else if (state_r == icm_pkg::ST_IDLE)
    begin
      xlat_ok_r    <= 1'b1;
      xlat_multi_r <= 1'b0;
    end
    else if (state_r == icm_pkg::ST_XLAT && xlat_done)
    begin
      xlat_ok_r    <= xlat_rsp.hit;
      xlat_multi_r <= xlat_rsp.multi;
      xlat_ppn_r   <= xlat_rsp.ppn;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      exc_r <= 1'b0;
    else
      exc_r <= (state_r == icm_pkg::ST_APB) && pwrite && is_tag && is_assoc && xlat_multi_r;
  end

  // ********************
  // APB read data
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end
    else if (state_r == icm_pkg::ST_IDLE && apb_acc)
    begin
      slverr_r <= !(is_tag || is_data || is_ctrl || is_stat);
      prdata_r <= '0;
      if (!pwrite)
      begin
        if (is_tag)
          prdata_r <= {3'h0, tag_mem[map_line], 9'h0, valid_r[map_line]};
        else if (is_data)
          prdata_r <= data_mem[{map_line, map_word}];
        else if (is_ctrl)
          prdata_r <= {30'h0, ctrl_r};
        else if (is_stat)
          prdata_r <= {23'h0, last_line_r, last_hit_r};
      end
    end
  end

  // ********************
  // Outputs
  // ********************
  assign pready        = (state_r == icm_pkg::ST_APB);
  assign prdata        = prdata_r;
  assign pslverr       = (state_r == icm_pkg::ST_APB) && slverr_r;
  assign fetch_ack     = ack_r;
  assign fetch_instr   = instr_r;
  assign fetch_hit     = hit_r;
  assign fetch_err     = err_r;
  assign mem_req       = (state_r == icm_pkg::ST_FILL) || (state_r == icm_pkg::ST_SINGLE);
  assign mem_addr      = (state_r == icm_pkg::ST_FILL) ? {pa_r[28:5], fill_word, 2'b00} : pa_r;
  assign xlat_req      = (state_r == icm_pkg::ST_XLAT);
  assign xlat_va       = pwdata[icm_pkg::VA_HI:icm_pkg::TAG_LO];
  assign multi_hit_exc = exc_r;

endmodule : icm_top

/* File: icm_pkg.sv */
// Purpose: Constants and carrier types for the mapped instruction store
// Assumes: One core clock, power-on reset on presetn
// Notes:   Operation list below
//
// Operation
// - Store has 256 lines, each 19-bit tag, valid flag, 32 data bytes.
// - Tag holds address bits 28..10; no reset ever initialises tags.
// - Power-on reset clears all valid flags; manual reset keeps them.
// - Line data is never initialised by either reset.
// - Lookup only when store enabled and fetch area is cacheable.
// - Line chosen by address bits 12..5; tag compared to translated 28..10.
// - Hit needs tag match and valid set; otherwise it is a miss.
// - Hit returns the longword picked by address bits 4..2.
// - Miss fills whole line wraparound from requested word, forwarding it first.
// - Tag written and valid set only after the whole line arrived.
// - High-bit index select uses address bit 25, two 4-Kbyte halves.
// - Mapped arrays take longword data accesses only; no fetches there.
// - Reserved bits written as zero; reads of them are undefined.
// - Tag array decoded at code f0, entry bits 12..5, no index mode.
// - Address bit 3 selects an associative tag-array write.
// - Tag word: bits 31..10 tag, bit 0 valid; 31..29 only associative.
// - Tag-array read returns tag and valid directly, never associative.
// - Plain tag-array write stores given tag and valid into the entry.
// - Associative write translates, compares, writes valid only on valid match.
// - Multiple translation hits raise the multiple-hit exception, no write.
// - Data array at code f1, entry bits 12..5, longword bits 4..2.

package icm_pkg;

  // ********************
  // Geometry
  // ********************
  localparam int LINES      = 256;
  localparam int WORDS      = 8;
  localparam int TAG_W      = 19;
  localparam int IDX_W      = 8;
  localparam int WRD_W      = 3;

  // ********************
  // Address fields
  // ********************
  localparam int REGION_HI  = 31;
  localparam int REGION_LO  = 24;
  localparam int IDX_HI     = 12;
  localparam int IDX_LO     = 5;
  localparam int IDX_ALT    = 25;
  localparam int WRD_HI     = 4;
  localparam int WRD_LO     = 2;
  localparam int TAG_HI     = 28;
  localparam int TAG_LO     = 10;
  localparam int ASSOC_BIT  = 3;
  localparam int VALID_BIT  = 0;
  localparam int VA_HI      = 31;

  // ********************
  // Region codes and control offsets
  // ********************
  localparam logic [7:0]  TAG_REGION  = 8'hf0;
  localparam logic [7:0]  DATA_REGION = 8'hf1;
  localparam logic [31:0] CTRL_ADDR   = 32'hf200_0000;
  localparam logic [31:0] STAT_ADDR   = 32'hf200_0004;
  localparam int          CTRL_EN_BIT = 0;
  localparam int          CTRL_IX_BIT = 1;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;

  // ********************
  // Carriers
  // ********************
  typedef struct packed {
    logic [31:0] ea;
    logic [28:0] pa;
    logic        cacheable;
  } icm_fetch_t;

  typedef struct packed {
    logic        hit;
    logic        multi;
    logic [18:0] ppn;
  } icm_xlat_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FILL,
    ST_SINGLE,
    ST_XLAT,
    ST_APB
  } icm_state_t;

endpackage : icm_pkg

/* File: icm_fill_seq.sv */
// Purpose: Wraparound longword sequencer for one line fill
// Assumes: start and step never in the same cycle
// Notes:   first marks the requested word, last the closing one
`timescale 1ns/1ns

module icm_fill_seq #(
  parameter int WORDS = icm_pkg::WORDS
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // Control
  input  wire logic                     start,
  input  wire logic [$clog2(WORDS)-1:0] start_word,
  input  wire logic                     step,
  // Position
  output logic      [$clog2(WORDS)-1:0] word,
  output logic                          first,
  output logic                          last
);

  localparam int WW = $clog2(WORDS);
  localparam logic [WW:0] FULL = (WW+1)'(WORDS);

  logic [WW-1:0] word_r;
  logic [WW:0]   left_r;

  // ********************
  // Wraparound walk
  // ********************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      word_r <= '0;
      left_r <= '0;
    end
    else if (start)
    begin
      word_r <= start_word;
      left_r <= FULL;
    end
    else if (step)
    begin
      word_r <= word_r + WW'(1);
      left_r <= left_r - (WW+1)'(1);
    end
  end

  assign word  = word_r;
  assign first = (left_r == FULL);
  assign last  = (left_r == (WW+1)'(1));

endmodule : icm_fill_seq

/* File: icm_chk.sv */
// Purpose: Port checker for the instruction store
// Assumes: One pclk domain, presetn async low
// Notes:   Bound from tb_top
`timescale 1ns/1ns

module icm_chk (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Fetch
  input wire icm_pkg::icm_fetch_t fetch_in,
  input wire logic                fetch_ack,
  input wire logic                fetch_hit,
  input wire logic                fetch_err,
  // Memory and translation
  input wire logic                mem_req,
  input wire logic [28:0]         mem_addr,
  input wire logic                mem_ack,
  input wire logic                xlat_req,
  input wire logic [21:0]         xlat_va,
  input wire logic                xlat_done,
  input wire icm_pkg::icm_xlat_t  xlat_rsp,
  input wire logic                multi_hit_exc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_one:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_slverr_qual:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_apb_answer:
    assert property (psel && $rose(penable) |-> ##[1:80] pready) else $error("no pready");
  a_ack_pulse:
    assert property (fetch_ack |=> !fetch_ack) else $error("fetch_ack too long");
  a_miss_forward:
    assert property (fetch_ack && !fetch_hit && !fetch_err |-> $past(mem_ack)) else $error("ack not after mem");
  a_err_mapped:
    assert property (fetch_ack && fetch_err |-> $past(fetch_in.ea[31:25]) == 7'h78) else $error("bad fetch_err");
  a_wrap_step:
    assert property (mem_req && mem_ack |=> !mem_req || (mem_addr[4:2] == $past(mem_addr[4:2]) + 3'h1
      && mem_addr[28:5] == $past(mem_addr[28:5]))) else $error("fill order wrong");
  a_mem_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("mem request dropped");
  a_xlat_va:
    assert property (xlat_req |-> psel && penable && !pready && xlat_va == pwdata[31:10])
      else $error("translation address wrong");
  a_multi_exc:
    assert property (xlat_done && xlat_rsp.multi |-> ##2 multi_hit_exc) else $error("no multi-hit exception");
  a_exc_cause:
    assert property (multi_hit_exc |-> $past(xlat_done, 2) && $past(xlat_rsp.multi, 2)) else $error("stray exception");
endmodule : icm_chk

/* File: icm_far.sv */
// Purpose: Memory and translation model at the far side
// Assumes: Requests held until answered
// Notes:   slow adds two wait cycles per word
`timescale 1ns/1ns

module icm_far_model (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Memory
  input  wire logic               mem_req,
  input  wire logic [28:0]        mem_addr,
  output logic                    mem_ack,
  output logic [31:0]             mem_rdata,
  // Translation
  input  wire logic               xlat_req,
  output logic                    xlat_done,
  output icm_pkg::icm_xlat_t      xlat_rsp,
  // Bench control
  input  wire logic               slow,
  input  wire icm_pkg::icm_xlat_t xlat_set
);
  logic [1:0] wait_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r    <= 2'h0;
    end
    else if (mem_req && !mem_ack && wait_r == {slow, 1'b0})
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= {3'h5, mem_addr};
      wait_r    <= 2'h0;
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r    <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      xlat_done <= 1'b0;
      xlat_rsp  <= '0;
    end
    else
    begin
      xlat_done <= xlat_req && !xlat_done;
      xlat_rsp  <= (xlat_req && !xlat_done) ? xlat_set : ~xlat_rsp;
    end
endmodule : icm_far_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the instruction store
// Assumes: Far model supplies memory and translation
// Notes:   One task per scenario
`timescale 1ns/1ns

module tb_top;
  logic                pclk, presetn, manual_reset, psel, penable, pwrite, pready, pslverr;
  logic                fetch_req, fetch_ack, fetch_hit, fetch_err, mem_req, mem_ack;
  logic                xlat_en, xlat_req, xlat_done, multi_hit_exc, slow, er;
  logic [31:0]         paddr, pwdata, prdata, fetch_instr, mem_rdata, rd;
  logic [28:0]         mem_addr;
  logic [21:0]         xlat_va;
  icm_pkg::icm_fetch_t fetch_in;
  icm_pkg::icm_xlat_t  xlat_rsp, xlat_set;
  int                  fails, total_checks, cyc, excs;
  localparam logic [28:0] PA = 29'h1234_5e4c;
  localparam logic [31:0] EA = 32'h0000_0a4c;
  localparam logic [31:0] TA = 32'hf000_0a40;

  icm_top DUT (.pclk(pclk), .presetn(presetn), .manual_reset(manual_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fetch_req(fetch_req), .fetch_in(fetch_in),
    .fetch_ack(fetch_ack), .fetch_instr(fetch_instr), .fetch_hit(fetch_hit), .fetch_err(fetch_err),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .xlat_en(xlat_en), .xlat_req(xlat_req), .xlat_va(xlat_va), .xlat_done(xlat_done),
    .xlat_rsp(xlat_rsp), .multi_hit_exc(multi_hit_exc));
  icm_far_model u_far (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .xlat_req(xlat_req), .xlat_done(xlat_done),
    .xlat_rsp(xlat_rsp), .slow(slow), .xlat_set(xlat_set));

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (multi_hit_exc === 1'b1)
      excs++;
    if (cyc == 20000)
    begin
      fails++;
      results;
    end
  end

  function automatic logic [31:0] tw(input logic [28:0] p, input logic v);
    return {3'h0, p[28:10], 9'h0, v};
  endfunction : tw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fetch(input logic [31:0] ea, input logic [28:0] pa, input logic c);
    @(posedge pclk);
    fetch_req <= 1'b1;
    fetch_in <= {ea, pa, c};
    do @(posedge pclk); while (fetch_ack !== 1'b1);
    fetch_req <= 1'b0;
  endtask : fetch

  task automatic t_uncached;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, TA + 32'(i * 128), 32'h0);
      chk({31'h0, rd[0]}, 32'h0);
    end
    fetch(EA, PA, 1'b1);
    chk(fetch_instr, {3'h5, PA});
    apb(1'b1, icm_pkg::CTRL_ADDR, 32'h1);
    fetch(EA, PA, 1'b0);
    chk({31'h0, fetch_hit}, 32'h0);
    apb(1'b0, TA, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
  endtask : t_uncached

  task automatic t_fill;
    slow <= 1'b1;
    fetch(EA, PA, 1'b1);
    chk(fetch_instr, {3'h5, PA});
    apb(1'b0, TA, 32'h0);
    chk(rd, tw(PA, 1'b1));
    for (int w = 0; w < 8; w++)
    begin
      apb(1'b0, 32'hf100_0a40 + 32'(w * 4), 32'h0);
      chk(rd, {3'h5, PA[28:5], 3'(w), 2'h0});
    end
  endtask : t_fill

  task automatic t_hit;
    fetch(EA + 32'h0c, PA + 29'h0c, 1'b1);
    chk({31'h0, fetch_hit}, 32'h1);
    chk(fetch_instr, {3'h5, PA + 29'h0c});
    apb(1'b1, 32'hf100_0a58, 32'hcafe_f00d);
    fetch(EA + 32'h0c, PA + 29'h0c, 1'b1);
    chk(fetch_instr, 32'hcafe_f00d);
    fetch(EA, PA ^ 29'h0010_0000, 1'b1);
    chk({31'h0, fetch_hit}, 32'h0);
    apb(1'b0, TA, 32'h0);
    chk(rd, tw(PA ^ 29'h0010_0000, 1'b1));
    apb(1'b1, TA, tw(PA, 1'b0));
    apb(1'b0, TA + 32'h8, 32'h0);
    chk(rd, tw(PA, 1'b0));
    fetch(EA, PA, 1'b1);
    chk({31'h0, fetch_hit}, 32'h0);
  endtask : t_hit

  task automatic assoc(input logic [31:0] d, input icm_pkg::icm_xlat_t x, input logic v);
    xlat_set <= x;
    apb(1'b1, TA + 32'h8, d);
    apb(1'b0, TA, 32'h0);
    chk({31'h0, rd[0]}, {31'h0, v});
  endtask : assoc

  task automatic t_assoc;
    int n;
    n = excs;
    xlat_en <= 1'b1;
    assoc(32'h0012_3400, '{1'b1, 1'b0, PA[28:10] ^ 19'h1}, 1'b1);
    assoc(32'h0012_3400, '{1'b0, 1'b0, PA[28:10]}, 1'b1);
    assoc(32'h0012_3400, '{1'b1, 1'b1, PA[28:10]}, 1'b1);
    chk(32'(excs - n), 32'h1);
    assoc(32'h0012_3400, '{1'b1, 1'b0, PA[28:10]}, 1'b0);
    xlat_en <= 1'b0;
    fetch(EA, PA, 1'b1);
    assoc(tw(PA, 1'b0), '0, 1'b0);
  endtask : t_assoc

  task automatic t_index;
    apb(1'b1, icm_pkg::CTRL_ADDR, 32'h3);
    fetch(32'h0200_0a4c, 29'h0abc_0a4c, 1'b1);
    apb(1'b0, icm_pkg::STAT_ADDR, 32'h0);
    chk(rd, {23'h0, 8'hd2, 1'b0});
    apb(1'b0, 32'hf000_1a40, 32'h0);
    chk(rd, tw(29'h0abc_0a4c, 1'b1));
    apb(1'b0, TA, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    @(posedge pclk);
    manual_reset <= 1'b1;
    @(posedge pclk);
    manual_reset <= 1'b0;
    apb(1'b0, 32'hf000_1a40, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    apb(1'b0, 32'hf300_0000, 32'h0);
    chk({31'h0, er}, 32'h1);
    fetch(32'hf100_0000, 29'h0, 1'b1);
    chk({31'h0, fetch_err}, 32'h1);
  endtask : t_index

  initial
  begin
    {presetn, manual_reset, psel, penable, pwrite, fetch_req, xlat_en, slow} = '0;
    {paddr, pwdata, fetch_in, xlat_set} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_uncached;
    t_fill;
    t_hit;
    t_assoc;
    t_index;
    results;
  end
endmodule : tb_top

bind icm_top icm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .fetch_in(fetch_in), .fetch_ack(fetch_ack),
  .fetch_hit(fetch_hit), .fetch_err(fetch_err), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .xlat_req(xlat_req), .xlat_va(xlat_va), .xlat_done(xlat_done),
  .xlat_rsp(xlat_rsp), .multi_hit_exc(multi_hit_exc));
